/* File: prsq_defines.svh */
// Purpose: offsets, field positions, reset values and timing for prsq
// Assumes: 32-bit classic wishbone, byte addresses
// Notes: definitions only
`ifndef PRSQ_DEFINES_SVH
`define PRSQ_DEFINES_SVH

// ****************************************************************
// timing
// ****************************************************************
`define PRSQ_CLK_HZ 50000000
`define PRSQ_LPO_HZ 32768

// ****************************************************************
// register offsets
// ****************************************************************
`define PRSQ_OFS_CTRL 8'h00
`define PRSQ_OFS_STATUS 8'h04
`define PRSQ_OFS_MIN 8'h08
`define PRSQ_OFS_FLAGS 8'h0c
`define PRSQ_OFS_CLKMAP 8'h10
`define PRSQ_OFS_RTMR 8'h18
`define PRSQ_OFS_RCFG 8'h40
`define PRSQ_OFS_RTIME 8'h80

// ****************************************************************
// fields and reset values
// ****************************************************************
`define PRSQ_CTRL_PD_B 0
`define PRSQ_CTRL_PD_W 1
`define PRSQ_CTRL_DOZE 2
`define PRSQ_CTRL_DEEP 3
`define PRSQ_CTRL_RST 32'h0000_0003
`define PRSQ_RCFG_TON 0
`define PRSQ_RCFG_TOFF 8
`define PRSQ_RCFG_DEP 16
`define PRSQ_FLAGS_PEND 8
`define PRSQ_RTMR_MASK 16

`endif

/* File: prsq_pkg.sv */
// Purpose: shared types of the power resource sequencer
// Assumes: nothing
// Notes: numbers live in prsq_defines.svh
package prsq_pkg;
	// per-resource state, always exactly one of four
	typedef enum logic [1:0] {
		RES_OFF,
		RES_TURN_ON,
		RES_ON,
		RES_TURN_OFF
	} prsq_res_state_e;

	// chip power mode
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_ACTIVE,
		MODE_DOZE,
		MODE_SAVE,
		MODE_DEEP,
		MODE_RESTORE
	} prsq_mode_e;
endpackage

/* File: prsq_res_if.sv */
// Purpose: link between the sequencer core and one resource slot
// Assumes: one interface per resource
// Notes: seq drives commands, slot answers with state and timer
`timescale 1ns/1ps
interface prsq_res_if #(parameter int P_TW = 8);
	import prsq_pkg::*;
	logic tick;
	logic clear;
	logic start_on;
	logic start_off;
	logic [P_TW-1:0] t_on;
	logic [P_TW-1:0] t_off;
	prsq_res_state_e state;
	logic [P_TW-1:0] timer;

	modport seq (output tick, clear, start_on, start_off, t_on, t_off,
		input state, timer);
	modport slot (input tick, clear, start_on, start_off, t_on, t_off,
		output state, timer);
endinterface

/* File: prsq_res_slot.sv */
// Purpose: one resource with its turn-on / turn-off timer
// Assumes: tick is a one-cycle low-power clock enable
// Notes: start commands are only given while the timer is idle
`timescale 1ns/1ps
module prsq_res_slot #(
	parameter int P_TW = 8
)(
	input wire logic i_clk,
	input wire logic i_nrst,
	prsq_res_if.slot bus
);
	import prsq_pkg::*;

	// ****************************************************************
	// state and timer
	// ****************************************************************
	// a single process keeps state and timer consistent
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			bus.state <= RES_OFF;
			bus.timer <= '0;
		end
		else if (bus.clear)
		begin
			bus.state <= RES_OFF;
			bus.timer <= '0;
		end
		else if (bus.tick)
		begin
			if (bus.timer != '0) // R08
			begin
				bus.timer <= bus.timer - P_TW'(1); // R10
				if (bus.timer == P_TW'(1))
				begin
					// flag flips, pending ends
					if (bus.state == RES_TURN_ON) // R13
						bus.state <= RES_ON; // R10
					else
						bus.state <= RES_OFF; // R10
				end
			end
			else if (bus.start_on)
			begin
				if (bus.t_on == '0)
					bus.state <= RES_ON; // R11
				else
				begin
					bus.state <= RES_TURN_ON;
					bus.timer <= bus.t_on; // R09
				end
			end
			else if (bus.start_off)
			begin
				if (bus.t_off == '0)
					bus.state <= RES_OFF; // R11
				else
				begin
					bus.state <= RES_TURN_OFF;
					bus.timer <= bus.t_off; // R09
				end
			end
		end
	end
endmodule

/* File: prsq_top.sv */
// Purpose: power resource sequencer with power-on gating and modes
// Assumes: 50 MHz clock, inputs synchronous, classic wishbone slave
// Notes: low-power clock is an enable pulse from a phase accumulator
// Functional notes
// R01: either power-on input enables core regulators
// R02: regulators off only when both inputs low
// R03: wireless power-on input controls wireless reset
// R04: pull-downs on after reset, software disables
// R05: requests: clocks, minimum mask, request timers
// R06: clock requests map to resource sets
// R07: each resource in exactly one of four states
// R08: timer zero when stable, nonzero in transition
// R09: load turn-on or turn-off delay on change
// R10: timer decrements per low-power tick, then settles
// R11: zero delay switches state immediately
// R12: required set recomputed every sequencer tick
// R13: timer expiry clears pending, inverts on flag
// R14: disable when on, unrequested, no powered dependents
// R15: enable when off, requested, dependencies all on
// R16: doze stops main clocks, sequencer keeps running
// R17: save core state before deep-sleep power off
// R18: restore on interrupt, host resume, timer expiry
// R19: outside logic re-enables regulators after power-down
// R20: shutdown tristates outputs, disables most inputs
// R21: power-up from shutdown retains no state
// R22: delays and dependencies held in programmable storage
// R23: request timers count low-power ticks, assert requests
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "prsq_defines.svh"
module prsq_top #(
	parameter int P_NRES = 8,
	parameter int P_TW = 8,
	parameter int P_NTMR = 2,
	parameter int P_CLK_HZ = `PRSQ_CLK_HZ,
	parameter int P_LPO_INC = `PRSQ_LPO_HZ
)(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_radio_b_power_on,
	input wire logic i_radio_w_power_on,
	input wire logic [1:0] i_clk_req,
	input wire logic i_ext_irq,
	input wire logic i_host_resume,
	output logic o_core_switching_regulator_en,
	output logic o_core_linear_regulator_en,
	output logic o_low_noise_linear_regulator_en,
	output logic o_radio_w_rst_n,
	output logic o_radio_b_pulldown_en,
	output logic o_radio_w_pulldown_en,
	output logic [P_NRES-1:0] o_resource_on_flag,
	output logic [P_NRES-1:0] o_resource_in_transition_flag,
	output logic o_main_clk_en,
	output logic o_core_power_en,
	output logic o_retention_save,
	output logic o_retention_restore,
	output logic o_io_tristate,
	output logic o_input_en
);
	import prsq_pkg::*;

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	// field layout leaves eight bits for masks and delays
	if (P_NRES < 1 || P_NRES > 8 || P_TW < 1 || P_TW > 8 ||
		P_NTMR < 1 || P_NTMR > 4 || P_LPO_INC < 1 ||
		P_LPO_INC >= P_CLK_HZ)
	begin : g_bad
		$error("prsq_top: unsupported parameter values");
	end

	localparam int AW = $clog2(P_CLK_HZ) + 1;
	localparam int NCLK = 2;

	// ****************************************************************
	// low-power clock enable
	// ****************************************************************
	logic [AW-1:0] lpo_acc;
	logic lpo_tick;
	logic [AW-1:0] next_lpo_acc;
	// fractional divide keeps the average rate exact
	assign next_lpo_acc = lpo_acc + AW'(P_LPO_INC);
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			lpo_acc <= '0;
			lpo_tick <= 1'b0;
		end
		else if (next_lpo_acc >= AW'(P_CLK_HZ))
		begin
			lpo_acc <= next_lpo_acc - AW'(P_CLK_HZ);
			lpo_tick <= 1'b1;
		end
		else
		begin
			lpo_acc <= next_lpo_acc;
			lpo_tick <= 1'b0;
		end
	end

	// ****************************************************************
	// power-on gating
	// ****************************************************************
	logic pwr_any;
	logic pwr_any_d;
	logic shut_clr;
	assign pwr_any = i_radio_b_power_on | i_radio_w_power_on; // R01
	// power-down holds registers, timers and slots at reset like a fresh power-up
	assign shut_clr = !pwr_any; // R21
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			pwr_any_d <= 1'b0;
		else
			pwr_any_d <= pwr_any;
	end

	// regulator enables and wireless reset follow the pins
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_core_switching_regulator_en <= 1'b0;
			o_core_linear_regulator_en <= 1'b0;
			o_low_noise_linear_regulator_en <= 1'b0;
			o_radio_w_rst_n <= 1'b0;
			o_io_tristate <= 1'b1;
			o_input_en <= 1'b0;
		end
		else
		begin
			o_core_switching_regulator_en <= pwr_any; // R01 R02
			o_core_linear_regulator_en <= pwr_any; // R01 R02
			o_low_noise_linear_regulator_en <= pwr_any; // R01 R02
			o_radio_w_rst_n <= i_radio_w_power_on; // R03
			o_io_tristate <= !pwr_any; // R20
			o_input_en <= pwr_any; // R20
		end
	end

	// ****************************************************************
	// programmable storage
	// ****************************************************************
	logic [31:0] ctrl;
	logic [P_NRES-1:0] min_mask;
	logic [P_NRES-1:0] clk_map [NCLK];
	logic [15:0] rtmr_cnt [P_NTMR];
	logic [P_NRES-1:0] rtmr_mask [P_NTMR];
	logic [P_TW-1:0] cfg_ton [P_NRES];
	logic [P_TW-1:0] cfg_toff [P_NRES];
	logic [P_NRES-1:0] cfg_dep [P_NRES];
	logic wb_wr;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic mode_take;
	logic tmr_expire;

	assign wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & !o_wb_ack;
	assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
		{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

	// byte lanes merge into the stored word
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] m);
		merge = (old_v & ~m) | (new_v & m);
	endfunction

	// control, minimum mask and clock map registers
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ctrl <= `PRSQ_CTRL_RST; // R04
			min_mask <= '0;
			for (int k = 0; k < NCLK; k++)
				clk_map[k] <= '0;
		end
		else if (shut_clr)
		begin
			ctrl <= `PRSQ_CTRL_RST; // R21
			min_mask <= '0;
			for (int k = 0; k < NCLK; k++)
				clk_map[k] <= '0;
		end
		else
		begin
			// mode requests self-clear once the mode machine takes them
			if (mode_take)
			begin
				ctrl[`PRSQ_CTRL_DOZE] <= 1'b0;
				ctrl[`PRSQ_CTRL_DEEP] <= 1'b0;
			end
			if (wb_wr && i_wb_adr == `PRSQ_OFS_CTRL)
				ctrl <= merge(ctrl, i_wb_dat, wmask) & 32'h0000_000f;
			if (wb_wr && i_wb_adr == `PRSQ_OFS_MIN)
				min_mask <= P_NRES'(merge(32'(min_mask), i_wb_dat, wmask));
			for (int k = 0; k < NCLK; k++)
				if (wb_wr && i_wb_adr == `PRSQ_OFS_CLKMAP + 8'(4 * k))
					clk_map[k] <= P_NRES'(merge(32'(clk_map[k]),
						i_wb_dat, wmask)); // R06
		end
	end

	// per-resource delays and dependency masks
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			for (int i = 0; i < P_NRES; i++)
			begin
				cfg_ton[i] <= '0;
				cfg_toff[i] <= '0;
				cfg_dep[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < P_NRES; i++)
				if (shut_clr)
				begin
					cfg_ton[i] <= '0;
					cfg_toff[i] <= '0;
					cfg_dep[i] <= '0;
				end
				else if (wb_wr && i_wb_adr == `PRSQ_OFS_RCFG + 8'(4 * i))
				begin
					// ton, toff and dependency mask in one word
					cfg_ton[i] <= P_TW'(merge(32'(cfg_ton[i]), i_wb_dat,
						wmask) >> `PRSQ_RCFG_TON); // R22
					cfg_toff[i] <= P_TW'(merge(32'(cfg_toff[i]) <<
						`PRSQ_RCFG_TOFF, i_wb_dat, wmask) >>
						`PRSQ_RCFG_TOFF); // R22
					cfg_dep[i] <= P_NRES'(merge(32'(cfg_dep[i]) <<
						`PRSQ_RCFG_DEP, i_wb_dat, wmask) >>
						`PRSQ_RCFG_DEP); // R22
				end
		end
	end

	// request timers: a write starts them, each tick counts down
	logic [P_NTMR-1:0] tmr_hit;
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			for (int k = 0; k < P_NTMR; k++)
			begin
				rtmr_cnt[k] <= '0;
				rtmr_mask[k] <= '0;
			end
			tmr_hit <= '0;
		end
		else
		begin
			for (int k = 0; k < P_NTMR; k++)
			begin
				tmr_hit[k] <= 1'b0;
				if (shut_clr)
				begin
					rtmr_cnt[k] <= '0;
					rtmr_mask[k] <= '0;
				end
				else if (wb_wr && i_wb_adr == `PRSQ_OFS_RTMR + 8'(4 * k))
				begin
					rtmr_cnt[k] <= 16'(merge(32'(rtmr_cnt[k]), i_wb_dat,
						wmask));
					rtmr_mask[k] <= P_NRES'(merge(32'(rtmr_mask[k]) <<
						`PRSQ_RTMR_MASK, i_wb_dat, wmask) >>
						`PRSQ_RTMR_MASK);
				end
				else if (lpo_tick && rtmr_cnt[k] != '0)
				begin
					rtmr_cnt[k] <= rtmr_cnt[k] - 16'h0001; // R23
					tmr_hit[k] <= (rtmr_cnt[k] == 16'h0001);
				end
			end
		end
	end
	assign tmr_expire = |tmr_hit;

	// ****************************************************************
	// resource sequencing
	// ****************************************************************
	prsq_res_if #(.P_TW(P_TW)) res_if [P_NRES] ();
	logic [P_NRES-1:0] on_now;
	logic [P_NRES-1:0] pend_now;
	logic [P_NRES-1:0] req_raw;
	logic [P_NRES-1:0] req_all;
	logic [P_NRES-1:0] en_go;
	logic [P_NRES-1:0] dis_go;

	// gather requests and close them over the dependency table
	always_comb
	begin
		req_raw = min_mask; // R05
		for (int k = 0; k < NCLK; k++)
			if (i_clk_req[k])
				req_raw = req_raw | clk_map[k]; // R06
		for (int k = 0; k < P_NTMR; k++)
			if (rtmr_cnt[k] != '0)
				req_raw = req_raw | rtmr_mask[k]; // R23
		req_all = req_raw;
		for (int n = 0; n < P_NRES; n++)
			for (int i = 0; i < P_NRES; i++)
				if (req_all[i])
					req_all = req_all | cfg_dep[i]; // R12
	end

	// enable and disable decisions for every resource
	always_comb
	begin
		for (int i = 0; i < P_NRES; i++)
		begin
			dis_go[i] = on_now[i] && !req_all[i]; // R14
			for (int j = 0; j < P_NRES; j++)
				if (cfg_dep[j][i] && (on_now[j] || pend_now[j]))
					dis_go[i] = 1'b0; // R14
			en_go[i] = !on_now[i] && !pend_now[i] && req_all[i] &&
				((cfg_dep[i] & ~(on_now & ~pend_now)) == '0); // R15
		end
	end

	for (genvar g = 0; g < P_NRES; g++)
	begin : g_res
		assign res_if[g].tick = lpo_tick; // R12
		assign res_if[g].clear = shut_clr; // R21
		assign res_if[g].start_on = en_go[g];
		assign res_if[g].start_off = dis_go[g] && !pend_now[g];
		assign res_if[g].t_on = cfg_ton[g];
		assign res_if[g].t_off = cfg_toff[g];
		// four-state enum keeps the states exclusive
		assign on_now[g] = (res_if[g].state == RES_ON) ||
			(res_if[g].state == RES_TURN_OFF); // R07
		assign pend_now[g] = res_if[g].timer != '0; // R08
		prsq_res_slot #(.P_TW(P_TW)) u_slot (
			.i_clk(i_clk),
			.i_nrst(i_nrst),
			.bus(res_if[g])
		);
	end

	// flags to the outside, one register stage
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_resource_on_flag <= '0;
			o_resource_in_transition_flag <= '0;
		end
		else
		begin
			o_resource_on_flag <= on_now; // R13
			o_resource_in_transition_flag <= pend_now; // R13
		end
	end

	// ****************************************************************
	// power modes
	// ****************************************************************
	prsq_mode_e mode;
	logic wake;
	assign wake = i_ext_irq | i_host_resume | tmr_expire; // R18
	assign mode_take = (mode == MODE_ACTIVE) &&
		(ctrl[`PRSQ_CTRL_DOZE] || ctrl[`PRSQ_CTRL_DEEP]);

	// save takes one cycle before core power drops, restore one cycle before the main clock returns
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			mode <= MODE_OFF;
		else if (!pwr_any)
			mode <= MODE_OFF;
		else
			unique case (mode)
				MODE_OFF: mode <= MODE_ACTIVE;
				MODE_ACTIVE:
					if (ctrl[`PRSQ_CTRL_DEEP])
						mode <= MODE_SAVE; // R17
					else if (ctrl[`PRSQ_CTRL_DOZE])
						mode <= MODE_DOZE; // R16
				MODE_DOZE:
					if (wake || i_clk_req != '0)
						mode <= MODE_ACTIVE; // R16
				MODE_SAVE: mode <= MODE_DEEP; // R17
				MODE_DEEP:
					if (wake)
						mode <= MODE_RESTORE; // R18
				MODE_RESTORE: mode <= MODE_ACTIVE;
			endcase
	end

	// mode outputs
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_main_clk_en <= 1'b0;
			o_core_power_en <= 1'b0;
			o_retention_save <= 1'b0;
			o_retention_restore <= 1'b0;
		end
		else
		begin
			// main clock drops with core power when both pins fall
			o_main_clk_en <= pwr_any && (mode == MODE_ACTIVE); // R16
			o_core_power_en <= pwr_any && mode != MODE_DEEP &&
				mode != MODE_OFF; // R17
			o_retention_save <= (mode == MODE_SAVE); // R17
			o_retention_restore <= (mode == MODE_RESTORE); // R18
		end
	end

	// pull-downs follow their control bits
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_radio_b_pulldown_en <= 1'b1; // R04
			o_radio_w_pulldown_en <= 1'b1; // R04
		end
		else
		begin
			o_radio_b_pulldown_en <= ctrl[`PRSQ_CTRL_PD_B]; // R04
			o_radio_w_pulldown_en <= ctrl[`PRSQ_CTRL_PD_W]; // R04
		end
	end

	// ****************************************************************
	// wishbone answer
	// ****************************************************************
	// interface arrays cannot be indexed by a loop variable
	logic [1:0] res_if_state [P_NRES];
	logic [P_TW-1:0] res_if_timer [P_NRES];
	for (genvar g = 0; g < P_NRES; g++)
	begin : g_rd
		assign res_if_state[g] = 2'(res_if[g].state);
		assign res_if_timer[g] = res_if[g].timer;
	end

	logic [31:0] rd_val;
	always_comb
	begin
		rd_val = 32'h0000_0000; // unmapped reads zero
		if (i_wb_adr == `PRSQ_OFS_CTRL)
			rd_val = ctrl;
		if (i_wb_adr == `PRSQ_OFS_STATUS)
			rd_val = {26'h0, pwr_any_d, i_radio_w_power_on,
				i_radio_b_power_on, 3'(mode)};
		if (i_wb_adr == `PRSQ_OFS_MIN)
			rd_val = 32'(min_mask);
		if (i_wb_adr == `PRSQ_OFS_FLAGS)
			rd_val = (32'(pend_now) << `PRSQ_FLAGS_PEND) | 32'(on_now);
		for (int k = 0; k < NCLK; k++)
			if (i_wb_adr == `PRSQ_OFS_CLKMAP + 8'(4 * k))
				rd_val = 32'(clk_map[k]);
		for (int k = 0; k < P_NTMR; k++)
			if (i_wb_adr == `PRSQ_OFS_RTMR + 8'(4 * k))
				rd_val = (32'(rtmr_mask[k]) << `PRSQ_RTMR_MASK) |
					32'(rtmr_cnt[k]);
		for (int i = 0; i < P_NRES; i++)
		begin
			if (i_wb_adr == `PRSQ_OFS_RCFG + 8'(4 * i))
				rd_val = (32'(cfg_dep[i]) << `PRSQ_RCFG_DEP) |
					(32'(cfg_toff[i]) << `PRSQ_RCFG_TOFF) | 32'(cfg_ton[i]);
			if (i_wb_adr == `PRSQ_OFS_RTIME + 8'(4 * i))
				rd_val = (32'(res_if_state[i]) << 8) | 32'(res_if_timer[i]);
		end
	end

	// one wait state, ack for one cycle, then drop
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= '0;
		end
		else
		begin
			o_wb_ack <= i_wb_cyc & i_wb_stb & !o_wb_ack;
			o_wb_dat <= rd_val;
		end
	end
endmodule

/* File: prsq_host_model.sv */
// Purpose: host model driving the two power-on control lines
// Assumes: levels change just after a rising clock edge
// Notes: host always drives both lines, so they never float
`timescale 1ns/1ps
module prsq_host_model (
	input wire logic i_clk,
	output logic o_b_on,
	output logic o_w_on
);
	// both lines low at start: chip in power-down
	initial
	begin
		o_b_on = 1'b0;
		o_w_on = 1'b0;
	end
	// raising a line is the only way out of power-down
	task automatic drive(input logic b, input logic w);
		@(posedge i_clk);
		o_b_on <= b;
		o_w_on <= w;
	endtask
endmodule

/* File: prsq_top_asserts.sv */
// Purpose: port-level checks of the power resource sequencer
// Assumes: bound to prsq_top, one clock domain
// Notes: resource checks watch slot 0 only, to stay cheap
`timescale 1ns/1ps
module prsq_top_asserts #(
	parameter int P_NRES = 8
)(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_radio_b_power_on,
	input wire logic i_radio_w_power_on,
	input wire logic o_core_switching_regulator_en,
	input wire logic o_core_linear_regulator_en,
	input wire logic o_low_noise_linear_regulator_en,
	input wire logic o_radio_w_rst_n,
	input wire logic o_radio_b_pulldown_en,
	input wire logic o_radio_w_pulldown_en,
	input wire logic [P_NRES-1:0] o_resource_on_flag,
	input wire logic [P_NRES-1:0] o_resource_in_transition_flag,
	input wire logic o_main_clk_en,
	input wire logic o_core_power_en,
	input wire logic o_retention_save,
	input wire logic o_retention_restore,
	input wire logic o_io_tristate,
	input wire logic o_input_en
);
	// ****************************************************************
	// helpers
	// ****************************************************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	wire any_on = i_radio_b_power_on | i_radio_w_power_on;
	wire regs_on = o_core_switching_regulator_en &
		o_core_linear_regulator_en & o_low_noise_linear_regulator_en;
	wire regs_any = o_core_switching_regulator_en |
		o_core_linear_regulator_en | o_low_noise_linear_regulator_en;
	// core power must still be up when the save pulse shows
	sequence s_into_deep;
		o_core_power_en ##1 !o_core_power_en;
	endsequence
	sequence s_wake;
		o_core_power_en ##1 o_main_clk_en;
	endsequence
	// ****************************************************************
	// checks
	// ****************************************************************
	a_any_pin_regs: assert property (any_on |=> regs_on)
		else $error("regulators not on with a power-on pin high");
	a_both_low_off: assert property (!any_on |=> !regs_any)
		else $error("regulator on with both power-on pins low");
	a_w_rst_follow: assert property
		(1'b1 |=> o_radio_w_rst_n == $past(i_radio_w_power_on))
		else $error("wireless reset does not follow its pin");
	a_pd_after_rst: assert property ($rose(i_nrst) |->
		o_radio_b_pulldown_en && o_radio_w_pulldown_en)
		else $error("pull-down off after reset");
	a_flip_on_done: assert property
		($fell(o_resource_in_transition_flag[0]) && $past(any_on) &&
		$past(any_on, 2) |->
		o_resource_on_flag[0] != $past(o_resource_on_flag[0]))
		else $error("state flag kept at end of transition");
	a_off_tristate: assert property ((!any_on) [*2] |->
		o_io_tristate && !o_input_en)
		else $error("outputs driven in shutdown");
	a_deep_no_clk: assert property
		(!o_core_power_en |-> !o_main_clk_en)
		else $error("main clock on with core unpowered");
	a_save_first: assert property (o_retention_save |-> s_into_deep)
		else $error("save pulse not followed by core power off");
	a_restore_wake: assert property
		(o_retention_restore |-> s_wake)
		else $error("restore not followed by active mode");
endmodule

/* File: tb_prsq_top.sv */
// Purpose: self-checking bench of the power resource sequencer
// Assumes: low-power tick every 10 clocks (P_LPO_INC raised)
// Notes: registers reached over classic wishbone
`timescale 1ns/1ps
`include "prsq_defines.svh"
module tb_prsq_top;
	import prsq_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0, ack;
	logic irq = 1'b0, resume = 1'b0, bon, won;
	logic [7:0] adr = 8'h00, on_f, tr_f;
	logic [31:0] wdat = 32'h0, rdat;
	logic [1:0] creq = 2'h0;
	logic sw, lin, ln, wrst_n, pdb, pdw, mclk, cpwr, sav, rsto, tri_s, in_en;
	wire [15:0] probe = {6'h00, cpwr, mclk, on_f};
	int err_total = 0;
	int checks_done = 0;
	logic [31:0] q;
	always #10 clk = ~clk;
	prsq_host_model prsq_host_model_i (.i_clk(clk), .o_b_on(bon),
		.o_w_on(won));
	prsq_top #(.P_LPO_INC(5000000)) prsq_top_i (.i_clk(clk),
		.i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_radio_b_power_on(bon),
		.i_radio_w_power_on(won), .i_clk_req(creq), .i_ext_irq(irq),
		.i_host_resume(resume), .o_core_switching_regulator_en(sw),
		.o_core_linear_regulator_en(lin),
		.o_low_noise_linear_regulator_en(ln), .o_radio_w_rst_n(wrst_n),
		.o_radio_b_pulldown_en(pdb), .o_radio_w_pulldown_en(pdw),
		.o_resource_on_flag(on_f), .o_resource_in_transition_flag(tr_f),
		.o_main_clk_en(mclk), .o_core_power_en(cpwr),
		.o_retention_save(sav), .o_retention_restore(rsto),
		.o_io_tristate(tri_s), .o_input_en(in_en));
	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic fail_wait();
		err_total++;
		conclude();
	endtask
	task automatic cmp(input string n, input logic [31:0] e,
		input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// request held until the edge that samples ack high
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		if (ack !== 1'b1)
			fail_wait();
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		cmp("read", e, q & m);
	endtask
	task automatic wait_on(input int i, input logic v);
		int n;
		n = 0;
		while (probe[i] !== v && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 400)
			fail_wait();
	endtask
	// length of a transition in clocks: ticks times ten
	task automatic span(input int i, input int e);
		int n;
		n = 0;
		while (tr_f[i] !== 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 400)
			fail_wait();
		n = 0;
		while (tr_f[i] === 1'b1 && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		cmp("span", e, n);
	endtask
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		cmp("pd_b", 1, pdb);
		cmp("pd_w", 1, pdw);
		// every pin pair, ending in power-down
		for (int i = 1; i < 5; i++)
		begin
			prsq_host_model_i.drive(i[1], i[0]);
			repeat (3) @(posedge clk);
			cmp("regs", {3{i[1] | i[0]}}, {sw, lin, ln});
			cmp("w_rst_n", i[0], wrst_n);
			cmp("tristate", !(i[1] | i[0]), tri_s);
		end
		wb(1'b1, `PRSQ_OFS_MIN, 32'h5); // write lost while powered down
		prsq_host_model_i.drive(1'b0, 1'b1);
		repeat (3) @(posedge clk);
		rdc(`PRSQ_OFS_MIN, 32'hff, 32'h0);
		rdc(`PRSQ_OFS_CTRL, 32'h3, 32'h3);
		wb(1'b1, `PRSQ_OFS_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		cmp("pd_off", 0, {pdb, pdw});
		rdc(8'h3c, 32'hffffffff, 32'h0);
		$display("end of pins and registers");
		// slot 0: on 3 ticks, off 2; slot 1 depends on 0, no delays
		wb(1'b1, `PRSQ_OFS_RCFG, 32'h0203);
		wb(1'b1, `PRSQ_OFS_RCFG + 8'h04, 32'h0001_0000);
		wb(1'b1, `PRSQ_OFS_MIN, 32'h3);
		span(0, 30);
		cmp("dep_wait", 0, on_f[1]);
		wait_on(1, 1'b1);
		cmp("zero_on", 0, tr_f[1]);
		rdc(`PRSQ_OFS_RTIME, 32'h3ff, 32'h200);
		rdc(`PRSQ_OFS_FLAGS, 32'hffff, 32'h3);
		wb(1'b1, `PRSQ_OFS_MIN, 32'h0);
		wait_on(1, 1'b0);
		cmp("dependent_up", 1, on_f[0] & !tr_f[0]);
		span(0, 20);
		cmp("off", 0, on_f[0]);
		$display("end of sequencing");
		wb(1'b1, `PRSQ_OFS_CLKMAP, 32'h4);
		creq <= 2'h1;
		wait_on(2, 1'b1);
		creq <= 2'h0;
		wait_on(2, 1'b0);
		wb(1'b1, `PRSQ_OFS_RTMR, 32'h0008_0005);
		wait_on(3, 1'b1);
		wait_on(3, 1'b0);
		$display("end of requests");
		wb(1'b1, `PRSQ_OFS_CTRL, 32'h4);
		wait_on(8, 1'b0);
		cmp("doze_core", 1, cpwr);
		creq <= 2'h2;
		wait_on(8, 1'b1);
		creq <= 2'h0;
		wb(1'b1, `PRSQ_OFS_CTRL, 32'h0);
		// deep sleep woken by interrupt, host resume, then timer
		for (int k = 0; k < 3; k++)
		begin
			if (k == 2)
				wb(1'b1, `PRSQ_OFS_RTMR, 32'h0000_0014);
			wb(1'b1, `PRSQ_OFS_CTRL, 32'h8);
			wait_on(9, 1'b0);
			irq <= (k == 0);
			resume <= (k == 1);
			@(posedge clk);
			irq <= 1'b0;
			resume <= 1'b0;
			wait_on(8, 1'b1);
			cmp("core_up", 1, cpwr);
		end
		$display("end of power modes");
		conclude();
	end
endmodule
bind prsq_top prsq_top_asserts #(.P_NRES(P_NRES)) prsq_top_asserts_i (
	.i_clk(i_clk), .i_nrst(i_nrst),
	.i_radio_b_power_on(i_radio_b_power_on),
	.i_radio_w_power_on(i_radio_w_power_on),
	.o_core_switching_regulator_en(o_core_switching_regulator_en),
	.o_core_linear_regulator_en(o_core_linear_regulator_en),
	.o_low_noise_linear_regulator_en(o_low_noise_linear_regulator_en),
	.o_radio_w_rst_n(o_radio_w_rst_n),
	.o_radio_b_pulldown_en(o_radio_b_pulldown_en),
	.o_radio_w_pulldown_en(o_radio_w_pulldown_en),
	.o_resource_on_flag(o_resource_on_flag),
	.o_resource_in_transition_flag(o_resource_in_transition_flag),
	.o_main_clk_en(o_main_clk_en), .o_core_power_en(o_core_power_en),
	.o_retention_save(o_retention_save),
	.o_retention_restore(o_retention_restore),
	.o_io_tristate(o_io_tristate), .o_input_en(o_input_en));
